// *** ahnd_params.svh ***
// constants for the shock and motion event engines
`ifndef AHND_PARAMS_SVH
`define AHND_PARAMS_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define AHND_IDX_INT_STATUS 8'h09
`define AHND_IDX_AXIS_SIGN 8'h0c
`define AHND_IDX_SOFT_RESET 8'h14
`define AHND_IDX_HIGH_EN 8'h17
`define AHND_IDX_MOTION_EN 8'h18
`define AHND_IDX_HYST 8'h24
`define AHND_IDX_HIGH_DUR 8'h25
`define AHND_IDX_HIGH_THR 8'h26
`define AHND_IDX_MOTION_DUR 8'h27
`define AHND_IDX_MOTION_THR 8'h29
`define AHND_IDX_LSB 2

// ==========================================
// field positions
`define AHND_ST_HIGH_BIT 1
`define AHND_ST_MOTION_BIT 3
`define AHND_AS_SIGN_BIT 3
`define AHND_MEN_SEL_BIT 3
`define AHND_HYST_MSB 7
`define AHND_HYST_LSB 6
`define AHND_MDUR_MSB 5

// ==========================================
// reset values
`define AHND_RST_HIGH_EN 8'h00
`define AHND_RST_MOTION_EN 8'h00
`define AHND_RST_HYST 8'h81
`define AHND_RST_HIGH_DUR 8'h0f
`define AHND_RST_HIGH_THR 8'hc0
`define AHND_RST_MOTION_DUR 8'h00
`define AHND_RST_MOTION_THR 8'h14
`define AHND_SOFT_RESET_KEY 8'hb6

// ==========================================
// scaling: shift from setting lsb to sample lsb
`define AHND_THR_SHIFT 3
`define AHND_HYST_SHIFT 7
`define AHND_SLOPE_SHIFT 2

// ==========================================
// no-motion delay table
`define AHND_NM_SHORT_LAST 6'd15
`define AHND_NM_MID_LAST 6'd21
`define AHND_NM_LONG_FIRST 6'd32
`define AHND_NM_MID_BASE 9'd40
`define AHND_NM_LONG_BASE 9'd88
`define AHND_NM_STEP_SHIFT 3

// ==========================================
// timing
`define AHND_CLK_KHZ 10000
`define AHND_HIGH_STEP_US 2000
`define AHND_TICK_S 1
`define AHND_HIGH_STEP_CYC (`AHND_HIGH_STEP_US * `AHND_CLK_KHZ / 1000)
`define AHND_TICK_CYC (`AHND_TICK_S * `AHND_CLK_KHZ * 1000)

`endif

// *** ahnd_pkg.sv ***
// types for the shock and motion event engines
`default_nettype none
package ahnd_pkg;
  typedef enum logic [1:0] {HG_ARMED, HG_ACTIVE, HG_REARM} ahnd_hg_state_t;
  typedef logic signed [11:0] ahnd_sample_t;
endpackage
`default_nettype wire

// *** ahnd_high_det.sv ***
// shock (high-g) detector with hysteresis and duration filter
`timescale 1ns/100ps
`default_nettype none
`include "ahnd_params.svh"
module ahnd_high_det import ahnd_pkg::*; #(
  parameter int DW = 12
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clr_i,
  input wire logic step_tick_i,
  // samples
  input wire logic signed [DW-1:0] acc_x_i,
  input wire logic signed [DW-1:0] acc_y_i,
  input wire logic signed [DW-1:0] acc_z_i,
  // settings
  input wire logic [2:0] en_i,
  input wire logic [7:0] shock_threshold_i,
  input wire logic [1:0] shock_hysteresis_i,
  input wire logic [7:0] dur_i,
  // status
  output logic evt_o,
  output logic [2:0] first_o,
  output logic sign_o
);
  logic signed [DW-1:0] acc [3];
  logic [2:0] above;
  logic [2:0] low;
  logic [DW-1:0] thr_cnt;
  logic [DW-1:0] hy_cnt;
  logic [DW-1:0] low_lim;
  logic above_any;
  logic below_all;
  logic [7:0] cnt_r;
  ahnd_hg_state_t state_r;

  assign acc[0] = acc_x_i;
  assign acc[1] = acc_y_i;
  assign acc[2] = acc_z_i;
  assign thr_cnt = DW'({shock_threshold_i, `AHND_THR_SHIFT'(0)}); // [RULE_02]
  assign hy_cnt = DW'({shock_hysteresis_i, `AHND_HYST_SHIFT'(0)}); // [RULE_03]
  assign low_lim = (thr_cnt > hy_cnt) ? thr_cnt - hy_cnt : '0;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic [DW-1:0] mag;
      assign mag = acc[g][DW-1] ? DW'(-acc[g]) : DW'(acc[g]);
      assign above[g] = en_i[g] && (mag > thr_cnt); // [RULE_01]
      assign low[g] = !en_i[g] || (mag < low_lim);
    end
  endgenerate

  assign above_any = |above; // [RULE_04]
  assign below_all = &low; // [RULE_05]

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || clr_i) begin
      state_r <= HG_ARMED;
      cnt_r <= '0;
      evt_o <= 1'b0;
      first_o <= '0;
      sign_o <= 1'b0;
    end else begin
      case (state_r)
        HG_ARMED: begin
          if (!above_any) begin
            cnt_r <= '0;
          end else if (step_tick_i) begin
            if (cnt_r == dur_i) begin // [RULE_06]
              state_r <= HG_ACTIVE;
              cnt_r <= '0;
              evt_o <= 1'b1; // [RULE_04]
              if (above[0]) begin // [RULE_09]
                first_o <= 3'b001;
                sign_o <= acc[0][DW-1]; // [RULE_11]
              end else if (above[1]) begin
                first_o <= 3'b010;
                sign_o <= acc[1][DW-1];
              end else begin
                first_o <= 3'b100;
                sign_o <= acc[2][DW-1];
              end
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
        HG_ACTIVE: begin
          if (!above_any) begin
            state_r <= HG_REARM;
            evt_o <= 1'b0; // [RULE_08]
            first_o <= '0; // [RULE_10]
            sign_o <= 1'b0;
          end
        end
        HG_REARM: begin
          if (!below_all) begin
            cnt_r <= '0;
          end else if (step_tick_i) begin
            if (cnt_r == dur_i) begin // [RULE_05]
              state_r <= HG_ARMED;
              cnt_r <= '0;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
        default: begin
          state_r <= HG_ARMED;
        end
      endcase
    end
  end
endmodule // ahnd_high_det
`default_nettype wire

// *** ahnd_motion_det.sv ***
// slow-motion / no-motion slope engine
`timescale 1ns/100ps
`default_nettype none
`include "ahnd_params.svh"
module ahnd_motion_det import ahnd_pkg::*; #(
  parameter int DW = 12
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clr_i,
  input wire logic sample_i,
  input wire logic sec_tick_i,
  // samples
  input wire logic signed [DW-1:0] acc_x_i,
  input wire logic signed [DW-1:0] acc_y_i,
  input wire logic signed [DW-1:0] acc_z_i,
  // settings
  input wire logic [2:0] en_i,
  input wire logic nomo_sel_i,
  input wire logic [5:0] dur_i,
  input wire logic [7:0] stillness_threshold_i,
  // status
  output logic evt_o
);
  logic signed [DW-1:0] acc [3];
  logic signed [DW-1:0] prev_r [3];
  logic prev_vld_r;
  logic [2:0] above;
  logic [2:0] still;
  logic above_any;
  logic below_all;
  logic [DW:0] thr_cnt;
  logic [2:0] run_r;
  logic [8:0] secs_r;
  logic [8:0] delay;
  logic mode_r;

  assign acc[0] = acc_x_i;
  assign acc[1] = acc_y_i;
  assign acc[2] = acc_z_i;
  assign thr_cnt = (DW+1)'({stillness_threshold_i, `AHND_SLOPE_SHIFT'(0)}); // [RULE_18]

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic signed [DW:0] slope;
      logic [DW:0] mag;
      assign slope = (DW+1)'(acc[g]) - (DW+1)'(prev_r[g]); // [RULE_23]
      assign mag = slope[DW] ? (DW+1)'(-slope) : (DW+1)'(slope);
      assign above[g] = en_i[g] && (mag > thr_cnt); // [RULE_17]
      assign still[g] = !en_i[g] || (mag < thr_cnt);
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || clr_i) begin
          prev_r[g] <= '0;
        end else if (sample_i) begin // [RULE_19]
          prev_r[g] <= acc[g];
        end
      end
    end
  endgenerate

  assign above_any = |above;
  assign below_all = &still;

  // delay code to seconds
  always_comb begin
    if (dur_i <= `AHND_NM_SHORT_LAST) begin // [RULE_14]
      delay = 9'(dur_i) + 9'd1;
    end else if (dur_i <= `AHND_NM_MID_LAST) begin
      delay = `AHND_NM_MID_BASE + 9'(9'(dur_i - 6'd16) << `AHND_NM_STEP_SHIFT);
    end else if (dur_i < `AHND_NM_LONG_FIRST) begin
      delay = `AHND_NM_LONG_BASE - 9'd8;
    end else begin
      delay = `AHND_NM_LONG_BASE + 9'(9'(dur_i - `AHND_NM_LONG_FIRST) << `AHND_NM_STEP_SHIFT);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prev_vld_r <= 1'b0;
    end else if (clr_i) begin
      prev_vld_r <= 1'b0;
    end else if (sample_i) begin
      prev_vld_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || clr_i) begin
      mode_r <= 1'b0;
      run_r <= '0;
      secs_r <= '0;
      evt_o <= 1'b0;
    end else if (mode_r != nomo_sel_i) begin
      mode_r <= nomo_sel_i;
      run_r <= '0;
      secs_r <= '0;
      evt_o <= 1'b0;
    end else if (mode_r) begin // [RULE_16]
      if (sample_i && prev_vld_r && !below_all) begin
        secs_r <= '0;
        evt_o <= 1'b0;
      end else if (sec_tick_i && !evt_o) begin // [RULE_15]
        if (secs_r + 9'd1 >= delay) begin // [RULE_13]
          evt_o <= 1'b1;
        end else begin
          secs_r <= secs_r + 9'd1;
        end
      end
    end else if (sample_i && prev_vld_r) begin
      if (above_any != evt_o) begin // [RULE_12]
        if (run_r == {1'b0, dur_i[1:0]}) begin
          evt_o <= above_any;
          run_r <= '0;
        end else begin
          run_r <= run_r + 3'd1;
        end
      end else begin
        run_r <= '0;
      end
    end
  end
endmodule // ahnd_motion_det
`default_nettype wire

// *** ahnd_top.sv ***
// shock and motion event engines with AHB-Lite register slave
//
// Functional notes
// RULE_01: shock check only on enabled axes
// RULE_02: shock threshold lsb scales with range
// RULE_03: shock hysteresis lsb scales with range
// RULE_04: shock raised after duration above threshold
// RULE_05: rearm after duration below threshold minus hysteresis
// RULE_06: shock delay is (duration+1) times 2 ms
// RULE_07: shock state readable in status register
// RULE_08: shock clears once below threshold
// RULE_09: one first-axis flag for triggering axis
// RULE_10: first-axis flags clear with shock event
// RULE_11: sign flag: zero positive, one negative
// RULE_12: slow motion uses N consecutive slope samples
// RULE_13: no-motion after delay with all slopes below
// RULE_14: duration code maps to no-motion delay table
// RULE_15: no-motion timed by one-second tick
// RULE_16: select bit one chooses no-motion mode
// RULE_17: motion engine watches enabled axes only
// RULE_18: slope threshold lsb scales with range
// RULE_19: slope samples spaced by sample strobe
// RULE_20: key write restores defaults
// RULE_21: host waits wake-up time after soft reset
// RULE_22: soft reset register reads zero
// RULE_23: slope is difference of consecutive samples
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ahnd_params.svh"
module ahnd_top import ahnd_pkg::*; #(
  parameter int DW = 12,
  parameter int STEP_CYC = `AHND_HIGH_STEP_CYC,
  parameter int TICK_CYC = `AHND_TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // filtered samples
  input wire logic sample_vld_i,
  input wire logic signed [DW-1:0] acc_x_i,
  input wire logic signed [DW-1:0] acc_y_i,
  input wire logic signed [DW-1:0] acc_z_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // event levels
  output logic shock_evt_o,
  output logic motion_evt_o
);
  // ==========================================
  // register state
  logic [7:0] high_en_r;
  logic [7:0] motion_en_r;
  logic [7:0] hyst_r;
  logic [7:0] high_dur_r;
  logic [7:0] high_thr_r;
  logic [7:0] motion_dur_r;
  logic [7:0] motion_thr_r;
  logic soft_rst_r;
  logic [31:0] step_cnt_r;
  logic [31:0] tick_cnt_r;
  logic step_tick_r;
  logic sec_tick_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic hg_evt;
  logic [2:0] hg_first;
  logic hg_sign;
  logic mo_evt;
  logic [7:0] status_val;
  logic [7:0] axis_val;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic [7:0] wr_byte;
  logic addr_ok;
  logic take;

  // ==========================================
  // ahb address and data phase
  assign take = hsel_i && hready_i && htrans_i[1];
  assign rd_idx = haddr_i[`AHND_IDX_LSB+7:`AHND_IDX_LSB];
  assign addr_ok = (haddr_i[31:`AHND_IDX_LSB+8] == '0) && (haddr_i[`AHND_IDX_LSB-1:0] == '0);
  assign wr_byte = hwdata_i[7:0];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
    end else if (hready_i) begin
      wr_pend_r <= take && hwrite_i && addr_ok;
      wr_idx_r <= rd_idx;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ==========================================
  // read mux
  assign status_val = 8'((hg_evt << `AHND_ST_HIGH_BIT) | (mo_evt << `AHND_ST_MOTION_BIT)); // [RULE_07]
  assign axis_val = 8'({hg_sign, hg_first}); // [RULE_09]

  always_comb begin
    case (rd_idx)
      `AHND_IDX_INT_STATUS: rd_val = status_val;
      `AHND_IDX_AXIS_SIGN: rd_val = axis_val;
      `AHND_IDX_SOFT_RESET: rd_val = 8'h00; // [RULE_22]
      `AHND_IDX_HIGH_EN: rd_val = high_en_r;
      `AHND_IDX_MOTION_EN: rd_val = motion_en_r;
      `AHND_IDX_HYST: rd_val = hyst_r;
      `AHND_IDX_HIGH_DUR: rd_val = high_dur_r;
      `AHND_IDX_HIGH_THR: rd_val = high_thr_r;
      `AHND_IDX_MOTION_DUR: rd_val = motion_dur_r;
      `AHND_IDX_MOTION_THR: rd_val = motion_thr_r;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      hrdata_o <= '0;
    end else if (take && !hwrite_i) begin
      if (!addr_ok) begin
        hrdata_o <= '0;
      end else if (wr_pend_r && wr_idx_r == rd_idx && rd_idx != `AHND_IDX_SOFT_RESET &&
                   rd_idx != `AHND_IDX_INT_STATUS && rd_idx != `AHND_IDX_AXIS_SIGN) begin
        hrdata_o <= {24'h000000, wr_byte};
      end else begin
        hrdata_o <= {24'h000000, rd_val};
      end
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_pend_r && wr_idx_r == `AHND_IDX_SOFT_RESET && wr_byte == `AHND_SOFT_RESET_KEY; // [RULE_20]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_rst_r) begin // [RULE_20]
      high_en_r <= `AHND_RST_HIGH_EN;
      motion_en_r <= `AHND_RST_MOTION_EN;
      hyst_r <= `AHND_RST_HYST;
      high_dur_r <= `AHND_RST_HIGH_DUR;
      high_thr_r <= `AHND_RST_HIGH_THR;
      motion_dur_r <= `AHND_RST_MOTION_DUR;
      motion_thr_r <= `AHND_RST_MOTION_THR;
    end else if (wr_pend_r) begin
      case (wr_idx_r)
        `AHND_IDX_HIGH_EN: high_en_r <= wr_byte;
        `AHND_IDX_MOTION_EN: motion_en_r <= wr_byte;
        `AHND_IDX_HYST: hyst_r <= wr_byte;
        `AHND_IDX_HIGH_DUR: high_dur_r <= wr_byte;
        `AHND_IDX_HIGH_THR: high_thr_r <= wr_byte;
        `AHND_IDX_MOTION_DUR: motion_dur_r <= wr_byte;
        `AHND_IDX_MOTION_THR: motion_thr_r <= wr_byte;
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // time bases
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_rst_r) begin
      step_cnt_r <= '0;
      step_tick_r <= 1'b0;
    end else if (step_cnt_r == 32'(STEP_CYC - 1)) begin // [RULE_06]
      step_cnt_r <= '0;
      step_tick_r <= 1'b1;
    end else begin
      step_cnt_r <= step_cnt_r + 32'd1;
      step_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || soft_rst_r) begin
      tick_cnt_r <= '0;
      sec_tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin // [RULE_15]
      tick_cnt_r <= '0;
      sec_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'd1;
      sec_tick_r <= 1'b0;
    end
  end

  // ==========================================
  // event engines
  ahnd_high_det #(
    .DW(DW)
  ) u_high (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clr_i(soft_rst_r),
    .step_tick_i(step_tick_r),
    .acc_x_i(acc_x_i),
    .acc_y_i(acc_y_i),
    .acc_z_i(acc_z_i),
    .en_i(high_en_r[2:0]),
    .shock_threshold_i(high_thr_r),
    .shock_hysteresis_i(hyst_r[`AHND_HYST_MSB:`AHND_HYST_LSB]),
    .dur_i(high_dur_r),
    .evt_o(hg_evt),
    .first_o(hg_first),
    .sign_o(hg_sign)
  );

  ahnd_motion_det #(
    .DW(DW)
  ) u_motion (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clr_i(soft_rst_r),
    .sample_i(sample_vld_i),
    .sec_tick_i(sec_tick_r),
    .acc_x_i(acc_x_i),
    .acc_y_i(acc_y_i),
    .acc_z_i(acc_z_i),
    .en_i(motion_en_r[2:0]),
    .nomo_sel_i(motion_en_r[`AHND_MEN_SEL_BIT]),
    .dur_i(motion_dur_r[`AHND_MDUR_MSB:0]),
    .stillness_threshold_i(motion_thr_r),
    .evt_o(mo_evt)
  );

  // ==========================================
  // event outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      shock_evt_o <= 1'b0;
      motion_evt_o <= 1'b0;
    end else begin
      shock_evt_o <= hg_evt;
      motion_evt_o <= mo_evt;
    end
  end
endmodule // ahnd_top
`default_nettype wire

// *** ahnd_top_sva.sv ***
// assertion checker for the shock and motion register block
`timescale 1ns/100ps
`default_nettype none
`include "ahnd_params.svh"
module ahnd_top_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // event levels
  input wire logic shock_evt_o,
  input wire logic motion_evt_o
);
  localparam logic [31:0] SR_ADDR = {22'h0, `AHND_IDX_SOFT_RESET, 2'b00};
  localparam logic [31:0] HOLE_ADDR = 32'h000000c0;
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
  assign wr_take = hsel_i & hready_i & htrans_i[1] & hwrite_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  // ==========================================
  // bus behaviour
  a_resp_okay: assert property (disable iff (!rst_b_i) hresp_o == 1'b0)
    else $error("bus response not okay");
  a_reset_quiet: assert property (!rst_b_i |=> hrdata_o == 32'h0 && !hreadyout_o && !shock_evt_o && !motion_evt_o)
    else $error("outputs not cleared by reset");
  a_zero_wait: assert property (disable iff (!rst_b_i) $past(rst_b_i) |-> hreadyout_o)
    else $error("wait state inserted");
  a_wo_reads_zero: assert property (disable iff (!rst_b_i) rd_take && haddr_i == SR_ADDR |=> hrdata_o == 32'h0)
    else $error("soft reset register read not zero");
  a_upper_zero: assert property (disable iff (!rst_b_i) rd_take |=> hrdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_hole_reads_zero: assert property (disable iff (!rst_b_i)
    rd_take && (haddr_i[1:0] != 2'b00 || haddr_i == HOLE_ADDR) |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (disable iff (!rst_b_i) !rd_take |=> $stable(hrdata_o))
    else $error("read data changed without read");
  a_soft_restart: assert property (disable iff (!rst_b_i)
    wr_take && haddr_i == SR_ADDR ##1 hwdata_i[7:0] == `AHND_SOFT_RESET_KEY |-> ##[1:4] !shock_evt_o && !motion_evt_o)
    else $error("events survive soft reset");
  // ==========================================
  // covers
  c_shock_rise: cover property (disable iff (!rst_b_i) $rose(shock_evt_o));
  c_motion_rise: cover property (disable iff (!rst_b_i) $rose(motion_evt_o));
  c_soft_key: cover property (disable iff (!rst_b_i) wr_take && haddr_i == SR_ADDR ##1 hwdata_i[7:0] == 8'hb6);
endmodule // ahnd_top_sva

bind ahnd_top ahnd_top_sva u_sva (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .shock_evt_o(shock_evt_o), .motion_evt_o(motion_evt_o)
);
`default_nettype wire

// *** ahnd_host_model.sv ***
// host-side ahb-lite master model for the register slave
`timescale 1ns/100ps
`default_nettype none
`include "ahnd_params.svh"
module ahnd_host_model #(
  parameter int WAKE_CYC = 20,
  parameter int LIMIT = 50
) (
  // clock
  input wire logic ref_clk_i,
  // ahb-lite master side
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end
  // waits for an edge that samples ready high
  task automatic wait_ready(output bit to);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    while (hready_i !== 1'b1 && n < LIMIT) begin
      n++;
      @(posedge ref_clk_i);
    end
    to = (n >= LIMIT);
  endtask
  // one single word transfer, address phase then data phase
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [7:0] wd,
                      output logic [31:0] rd, output bit to);
    bit t1;
    @(posedge ref_clk_i);
    hsel_o <= 1'b1;
    haddr_o <= addr;
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o <= 3'b010;
    wait_ready(t1);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    haddr_o <= ~addr;
    hwdata_o <= {24'h0, wd};
    wait_ready(to);
    rd = hrdata_i;
    hwdata_o <= ~{24'h0, wd};
    to = to | t1;
  endtask
  // key write, then hold off all access for the wake-up time
  task automatic soft_reset(output bit to);
    logic [31:0] q;
    xfer(1'b1, {22'h0, `AHND_IDX_SOFT_RESET, 2'b00}, `AHND_SOFT_RESET_KEY, q, to);
    repeat (WAKE_CYC) @(posedge ref_clk_i);
  endtask
endmodule // ahnd_host_model
`default_nettype wire

// *** ahnd_top_test.sv ***
// self-checking bench for the shock and motion register block
`timescale 1ns/100ps
`default_nettype none
`include "ahnd_params.svh"
`define CHK(nm, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); \
  end \
end
module ahnd_top_test;
  logic ref_clk, rst_b, vld;
  logic signed [11:0] ax, ay, az;
  wire logic hsel, hwrite, hready, hresp, shock, motion;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  int num_errors, n_compared;
  bit to;
  logic [31:0] hrdata_q;
  logic [7:0] ridx [7] = '{`AHND_IDX_HIGH_EN, `AHND_IDX_MOTION_EN, `AHND_IDX_HYST, `AHND_IDX_HIGH_DUR,
                           `AHND_IDX_HIGH_THR, `AHND_IDX_MOTION_DUR, `AHND_IDX_MOTION_THR};
  logic [7:0] rval [7] = '{`AHND_RST_HIGH_EN, `AHND_RST_MOTION_EN, `AHND_RST_HYST, `AHND_RST_HIGH_DUR,
                           `AHND_RST_HIGH_THR, `AHND_RST_MOTION_DUR, `AHND_RST_MOTION_THR};
  int nm_code [6] = '{0, 15, 16, 21, 32, 63};
  int nm_secs [6] = '{1, 16, 40, 80, 88, 336};
  ahnd_top #(.DW(12), .STEP_CYC(4), .TICK_CYC(40)) uut (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b), .sample_vld_i(vld), .acc_x_i(ax), .acc_y_i(ay), .acc_z_i(az),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .shock_evt_o(shock), .motion_evt_o(motion)
  );
  ahnd_host_model #(.WAKE_CYC(20), .LIMIT(50)) host (
    .ref_clk_i(ref_clk), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata), .hready_i(hready), .hrdata_i(hrdata)
  );
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ==========================================
  // tasks
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] q);
    host.xfer(w, a, d, q, to);
    if (to) begin
      num_errors++;
      $display("mismatch bus ready expected 1 seen 0");
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, {22'h0, idx, 2'b00}, d, q);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, {22'h0, idx, 2'b00}, 8'h00, q);
    `CHK($sformatf("register %h", idx), exp, q)
  endtask
  task automatic samp(input int x, input int y, input int z);
    @(posedge ref_clk);
    ax <= 12'(x);
    ay <= 12'(y);
    az <= 12'(z);
    vld <= 1'b1;
    @(posedge ref_clk);
    vld <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic await(input bit mot, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((mot ? motion : shock) !== lvl && n < lim) begin
      n++;
      @(posedge ref_clk);
    end
    `CHK("event level", lvl, (mot ? motion : shock))
    if ((mot ? motion : shock) !== lvl) end_of_test();
  endtask
  task automatic hold_chk(input bit mot, input logic lvl, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge ref_clk);
      if ((mot ? motion : shock) !== lvl) bad = 1'b1;
    end
    `CHK("event hold", 1'b0, bad)
  endtask
  task automatic nomo_chk(input int code, input int secs);
    int i;
    wr(`AHND_IDX_MOTION_DUR, 8'(code));
    samp(400, 0, 0);
    for (i = 0; i < secs * 5 + 10 && motion !== 1'b1; i++) samp(400, 0, 0);
    `CHK("no-motion delay", 1'b1, motion === 1'b1 && i * 8 >= (secs - 1) * 40 && i * 8 <= (secs + 1) * 40 + 16)
    if (motion !== 1'b1) end_of_test();
    samp(0, 0, 0);
    await(1'b1, 1'b0, 20);
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    vld = 1'b0;
    ax = 12'sh0;
    ay = 12'sh0;
    az = 12'sh0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int k = 0; k < 7; k++) rchk(ridx[k], {24'h0, rval[k]});
    rchk(`AHND_IDX_SOFT_RESET, 32'h0);
    rchk(8'h30, 32'h0);
    bus(1'b0, 32'h0000005d, 8'h00, hrdata_q);
    `CHK("misaligned read", 32'h0, hrdata_q)
    wr(`AHND_IDX_INT_STATUS, 8'hff);
    rchk(`AHND_IDX_INT_STATUS, 32'h0);
    wr(`AHND_IDX_HIGH_EN, 8'h01);
    wr(`AHND_IDX_HIGH_DUR, 8'h03);
    wr(`AHND_IDX_HIGH_THR, 8'h20);
    wr(`AHND_IDX_HYST, 8'h40);
    samp(0, 1000, 0);
    hold_chk(1'b0, 1'b0, 40);
    samp(-300, 1000, 0);
    hold_chk(1'b0, 1'b0, 2);
    await(1'b0, 1'b1, 40);
    rchk(`AHND_IDX_INT_STATUS, 32'h02);
    rchk(`AHND_IDX_AXIS_SIGN, 32'h09);
    samp(200, 1000, 0);
    await(1'b0, 1'b0, 20);
    rchk(`AHND_IDX_AXIS_SIGN, 32'h0);
    samp(300, 1000, 0);
    hold_chk(1'b0, 1'b0, 40);
    samp(0, 1000, 0);
    hold_chk(1'b0, 1'b0, 40);
    wr(`AHND_IDX_HIGH_EN, 8'h03);
    await(1'b0, 1'b1, 60);
    rchk(`AHND_IDX_AXIS_SIGN, 32'h02);
    samp(0, 0, 0);
    await(1'b0, 1'b0, 20);
    wr(`AHND_IDX_MOTION_EN, 8'h01);
    wr(`AHND_IDX_MOTION_DUR, 8'h01);
    wr(`AHND_IDX_MOTION_THR, 8'h04);
    samp(0, 0, 0);
    samp(0, 0, 0);
    samp(100, 0, 0);
    hold_chk(1'b1, 1'b0, 2);
    samp(200, 0, 0);
    await(1'b1, 1'b1, 20);
    rchk(`AHND_IDX_INT_STATUS, 32'h08);
    samp(200, 500, 0);
    hold_chk(1'b1, 1'b1, 2);
    samp(200, 0, 0);
    await(1'b1, 1'b0, 20);
    wr(`AHND_IDX_MOTION_EN, 8'h09);
    for (int k = 0; k < 6; k++) nomo_chk(nm_code[k], nm_secs[k]);
    host.soft_reset(to);
    `CHK("soft reset ready", 1'b0, to)
    rchk(`AHND_IDX_MOTION_EN, 32'h0);
    rchk(`AHND_IDX_MOTION_THR, {24'h0, `AHND_RST_MOTION_THR});
    rchk(`AHND_IDX_SOFT_RESET, 32'h0);
    end_of_test();
  end
endmodule // ahnd_top_test
`default_nettype wire
